/* rtl/fle_pkg.sv */
// constants shared by the fabric logic element block
// assumes a 32-bit classic wishbone master on the same clock
package fle_pkg;

  // bus geometry
  localparam int unsigned FLE_AW = 8;
  localparam int unsigned FLE_DW = 32;

  // register byte offsets
  localparam logic [FLE_AW-1:0] ADDR_LUT_INIT = 8'h00;
  localparam logic [FLE_AW-1:0] ADDR_LUT_IN   = 8'h04;
  localparam logic [FLE_AW-1:0] ADDR_SEQ_CTRL = 8'h08;
  localparam logic [FLE_AW-1:0] ADDR_STATUS   = 8'h0c;

  // configuration string fields of the lut init register
  localparam int unsigned LUT4_LSB = 0;
  localparam int unsigned LUT3_LSB = 16;
  localparam int unsigned LUT2_LSB = 24;
  localparam int unsigned LUT1_LSB = 28;

  // sequential control register fields
  localparam int unsigned SC_DATA       = 0;
  localparam int unsigned SC_EN         = 1;
  localparam int unsigned SC_ALOAD_N    = 2;
  localparam int unsigned SC_ALOAD_VALN = 3;
  localparam int unsigned SC_SLOAD_N    = 4;
  localparam int unsigned SC_SLOAD_VAL  = 5;
  localparam int unsigned SC_LATCH      = 6;
  localparam int unsigned SC_FF_D       = 7;
  localparam int unsigned SC_FF_EN      = 8;
  localparam int unsigned SC_FF_PRE     = 9;
  localparam int unsigned SC_FF_CLR     = 10;
  localparam int unsigned SC_ROW_IN     = 11;
  localparam int unsigned SC_VOTE_LSB   = 12;
  localparam int unsigned SC_W          = 15;

  // status register fields
  localparam int unsigned ST_SEQ    = 4;
  localparam int unsigned ST_FF     = 5;
  localparam int unsigned ST_ROW_L  = 6;
  localparam int unsigned ST_ROW_R  = 7;
  localparam int unsigned ST_VOTE   = 8;

  // reset values
  localparam logic [31:0]     LUT_INIT_RST = 32'h0000_0000;
  localparam logic [3:0]      LUT_IN_RST   = 4'h0;
  localparam logic [SC_W-1:0] SEQ_CTRL_RST = 15'h0414;

  // polarity option of an enable, preset or clear pin
  typedef enum logic [1:0] {
    FLE_OPT_ABSENT,
    FLE_OPT_ACT_LOW,
    FLE_OPT_ACT_HIGH
  } fle_opt_t;

endpackage

/* rtl/fle_ff_if.sv */
// signals between the fabric top and its flip-flop variant
// assumes the user end drives d, en, pre and clr from registers
interface fle_ff_if;
  logic d;
  logic en;
  logic pre;
  logic clr;
  logic q;
  modport prim (input d, input en, input pre, input clr, output q);
  modport user (output d, output en, output pre, output clr, input q);
endinterface

/* rtl/fle_ff_variant.sv */
// one named flip-flop variant: edge, enable, preset, clear, output polarity
// assumes pre and clr come glitch free from flip-flops
module fle_ff_variant #(
  parameter bit               CLK_POL = 1'b1,
  parameter fle_pkg::fle_opt_t EN_OPT  = fle_pkg::FLE_OPT_ACT_HIGH,
  parameter fle_pkg::fle_opt_t PRE_OPT = fle_pkg::FLE_OPT_ABSENT,
  parameter fle_pkg::fle_opt_t CLR_OPT = fle_pkg::FLE_OPT_ACT_LOW,
  parameter bit               INV_OUT = 1'b0
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  fle_ff_if.prim    port
);
  import fle_pkg::*;

  function automatic logic opt_on(input fle_opt_t opt, input logic pin);
    unique case (opt)
      FLE_OPT_ACT_LOW:  opt_on = ~pin;
      FLE_OPT_ACT_HIGH: opt_on = pin;
      default:          opt_on = 1'b0;
    endcase
  endfunction

  logic q_q;
  wire  cap_clk = CLK_POL ? clk_i : ~clk_i;
  wire  en_on   = (EN_OPT == FLE_OPT_ABSENT) | opt_on(EN_OPT, port.en);
  wire  pre_on  = opt_on(PRE_OPT, port.pre);
  wire  clr_on  = opt_on(CLR_OPT, port.clr);

  // clear beats preset when both are asserted
  always_ff @(posedge cap_clk or posedge clr_on or posedge pre_on) begin
    if (clr_on) begin
      q_q <= 1'b0;
    end else if (pre_on) begin
      q_q <= 1'b1;
    end else if (rst_i) begin
      q_q <= 1'b0;
    end else if (en_on) begin
      q_q <= port.d;
    end
  end

  assign port.q = q_q ^ INV_OUT;

  a_ff_clr_force: assert property (@(posedge clk_i) disable iff (rst_i)
    clr_on |-> q_q == 1'b0) else $error("clear did not force zero");
  a_ff_pre_force: assert property (@(posedge clk_i) disable iff (rst_i)
    (pre_on && !clr_on) |-> q_q == 1'b1) else $error("preset did not force one");
  a_ff_out_pol: assert property (@(posedge clk_i) disable iff (rst_i)
    port.q == (INV_OUT ? ~q_q : q_q)) else $error("output polarity wrong");
  a_ff_rise_cap: assert property (@(posedge clk_i) disable iff (rst_i)
    (CLK_POL && en_on && !pre_on && !clr_on) |=> (clr_on || pre_on || q_q == $past(port.d)))
    else $error("rising edge capture missed");
  a_ff_en_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (CLK_POL && !en_on && !pre_on && !clr_on) |=> (clr_on || pre_on || $stable(q_q)))
    else $error("disabled flip-flop changed");
  a_ff_fall_cap: assert property (@(negedge clk_i) disable iff (rst_i)
    (!CLK_POL && en_on && !pre_on && !clr_on) |=> (clr_on || pre_on || q_q == $past(port.d)))
    else $error("falling edge capture missed");

endmodule

/* rtl/fle_fabric.sv */
// fabric logic element block: luts, sequential element, flip-flop variant,
// row buffer and voted local reset, all steered from wishbone registers
// assumes a classic wishbone master on clk_i and synchronous rst_i
// Function
// - two-input lut picks init by B,A
// - three-input lut picks init by C,B,A
// - four-input lut picks init by D,C,B,A
// - sequential element updates only when enabled or async loaded
// - async load forces output to inverted value
// - sync load takes static value at edge
// - clock polarity option picks capture edge
// - enable option active low or high
// - preset option sets one, either polarity
// - clear option forces zero, either polarity
// - variant gives true or inverted output
// - row buffer copies input to both sides
// - voted reset outputs majority of three
//
// Implementation choices: the Wishbone slave port and the register offsets.
module fle_fabric #(
  parameter bit               FF_CLK_POL = 1'b1,
  parameter fle_pkg::fle_opt_t FF_EN_OPT  = fle_pkg::FLE_OPT_ACT_HIGH,
  parameter fle_pkg::fle_opt_t FF_PRE_OPT = fle_pkg::FLE_OPT_ABSENT,
  parameter fle_pkg::fle_opt_t FF_CLR_OPT = fle_pkg::FLE_OPT_ACT_LOW,
  parameter bit               FF_INV_OUT = 1'b0
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [fle_pkg::FLE_AW-1:0] wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [fle_pkg::FLE_DW-1:0] wb_dat_i,
  output logic      [fle_pkg::FLE_DW-1:0] wb_dat_o,
  output logic                           wb_ack_o,
  output logic                           seq_q_o,
  output logic                           ff_q_o,
  output logic                           row_out_left_o,
  output logic                           row_out_right_o,
  output logic                           voted_local_reset_o
);
  import fle_pkg::*;

  // byte-lane merge of a write into an old word
  function automatic logic [31:0] merge_sel(input logic [31:0] old_w,
                                            input logic [31:0] new_w,
                                            input logic [3:0]  sel);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    merge_sel = res;
  endfunction

  // configuration string lookup, index already ordered msb first
  function automatic logic lut_pick(input logic [15:0] init, input logic [3:0] idx);
    lut_pick = init[idx];
  endfunction

  // two of three vote
  function automatic logic majority(input logic [2:0] v);
    majority = (v[0] & v[1]) | (v[1] & v[2]) | (v[0] & v[2]);
  endfunction

  logic [31:0]     lut_init_q;
  logic [3:0]      lut_in_q;
  logic [SC_W-1:0] seq_ctrl_q;
  logic            seq_q;
  logic            ack_q;
  logic [31:0]     rdat_q;

  // bus decode
  wire        wb_req     = wb_cyc_i & wb_stb_i;
  wire        wb_take    = wb_req & ~ack_q;
  wire        wb_commit  = wb_req & ack_q & wb_we_i;
  wire        hit_init   = (wb_adr_i == ADDR_LUT_INIT);
  wire        hit_in     = (wb_adr_i == ADDR_LUT_IN);
  wire        hit_ctrl   = (wb_adr_i == ADDR_SEQ_CTRL);
  wire        hit_status = (wb_adr_i == ADDR_STATUS);
  wire [31:0] init_wr    = merge_sel(lut_init_q, wb_dat_i, wb_sel_i);
  wire [31:0] in_wr      = merge_sel({28'h0, lut_in_q}, wb_dat_i, wb_sel_i);
  wire [31:0] ctrl_wr    = merge_sel({17'h0, seq_ctrl_q}, wb_dat_i, wb_sel_i);

  // lut inputs, shared among the four tables
  wire in_a = lut_in_q[0];
  wire in_b = lut_in_q[1];
  wire in_c = lut_in_q[2];
  wire in_d = lut_in_q[3];

  wire lut1_y = lut_pick({14'h0, lut_init_q[LUT1_LSB +: 2]}, {3'b000, in_a});
  wire lut2_y = lut_pick({12'h0, lut_init_q[LUT2_LSB +: 4]}, {2'b00, in_b, in_a});
  wire lut3_y = lut_pick({8'h0, lut_init_q[LUT3_LSB +: 8]}, {1'b0, in_c, in_b, in_a});
  wire lut4_y = lut_pick(lut_init_q[LUT4_LSB +: 16], {in_d, in_c, in_b, in_a});

  // sequential element controls
  wire se_data   = seq_ctrl_q[SC_DATA];
  wire se_en     = seq_ctrl_q[SC_EN];
  wire se_al_n   = seq_ctrl_q[SC_ALOAD_N];
  wire se_alv_n  = seq_ctrl_q[SC_ALOAD_VALN];
  wire se_sl_n   = seq_ctrl_q[SC_SLOAD_N];
  wire se_slv    = seq_ctrl_q[SC_SLOAD_VAL];
  wire se_latch  = seq_ctrl_q[SC_LATCH];
  wire [2:0] vote_in = seq_ctrl_q[SC_VOTE_LSB +: 3];

  // output forced while async load is low, without waiting for an edge
  wire seq_out = se_al_n ? seq_q : ~se_alv_n;
  wire row_in  = seq_ctrl_q[SC_ROW_IN];
  wire voted   = majority(vote_in);

  fle_ff_if ff_bus ();
  assign ff_bus.d   = seq_ctrl_q[SC_FF_D];
  assign ff_bus.en  = seq_ctrl_q[SC_FF_EN];
  assign ff_bus.pre = seq_ctrl_q[SC_FF_PRE];
  assign ff_bus.clr = seq_ctrl_q[SC_FF_CLR];

  fle_ff_variant #(
    .CLK_POL (FF_CLK_POL),
    .EN_OPT  (FF_EN_OPT),
    .PRE_OPT (FF_PRE_OPT),
    .CLR_OPT (FF_CLR_OPT),
    .INV_OUT (FF_INV_OUT)
  ) u_ff (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .port  (ff_bus.prim)
  );

  wire [31:0] status_w = {23'h0, voted, row_in, row_in, ff_bus.q, seq_out,
                          lut4_y, lut3_y, lut2_y, lut1_y};
  wire [31:0] rd_mux = hit_init   ? lut_init_q :
                       hit_in     ? {28'h0, lut_in_q} :
                       hit_ctrl   ? {17'h0, seq_ctrl_q} :
                       hit_status ? status_w : 32'h0000_0000;

  // one wait state: ack follows the request edge, drops the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q  <= wb_take;
      rdat_q <= wb_take ? rd_mux : rdat_q;
    end
  end

  // writes land on the edge where the master sees ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lut_init_q <= LUT_INIT_RST;
      lut_in_q   <= LUT_IN_RST;
      seq_ctrl_q <= SEQ_CTRL_RST;
    end else if (wb_commit) begin
      if (hit_init) begin
        lut_init_q <= init_wr;
      end
      if (hit_in) begin
        lut_in_q <= in_wr[3:0];
      end
      if (hit_ctrl) begin
        seq_ctrl_q <= ctrl_wr[SC_W-1:0];
      end
    end
  end

  // latch mode has no defined output, so the state holds unless async load is low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seq_q <= 1'b0;
    end else if (!se_al_n) begin
      seq_q <= ~se_alv_n;
    end else if (se_latch) begin
      seq_q <= seq_q;
    end else if (se_en) begin
      seq_q <= se_sl_n ? se_data : se_slv;
    end
  end

  assign wb_ack_o            = ack_q;
  assign wb_dat_o            = rdat_q;
  assign seq_q_o             = seq_out;
  assign ff_q_o              = ff_bus.q;
  assign row_out_left_o      = row_in;
  assign row_out_right_o     = row_in;
  assign voted_local_reset_o = voted;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_bus_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  sequence s_bus_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  sequence s_seq_clocked;
    se_al_n && !se_latch && se_en;
  endsequence

  sequence s_bus_commit;
    wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  endsequence

  a_bus_ack_once: assert property (s_bus_req |=> s_bus_ack_pulse)
    else $error("ack not a single pulse after request");
  a_bus_ctrl_write: assert property (
    (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && hit_ctrl && wb_sel_i == 4'hf)
    |=> seq_ctrl_q == $past(wb_dat_i[SC_W-1:0]))
    else $error("control write lost");
  a_bus_status_read: assert property (
    (s_bus_req ##0 (!wb_we_i && hit_status)) |=> wb_dat_o[ST_SEQ] == $past(seq_out))
    else $error("status read shows wrong element state");
  a_bus_idle_quiet: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without a request");
  a_bus_rdata_hold: assert property (!wb_take |=> $stable(wb_dat_o))
    else $error("read data moved without a request");
  a_bus_hole_zero: assert property (
    (s_bus_req ##0 (!wb_we_i && !(hit_init || hit_in || hit_ctrl || hit_status)))
    |=> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_bus_in_write: assert property ((s_bus_commit ##0 (hit_in && wb_sel_i[0]))
    |=> lut_in_q == $past(wb_dat_i[3:0]))
    else $error("lut input write lost");
  a_bus_status_ro: assert property ((s_bus_commit ##0 hit_status)
    |=> (seq_ctrl_q == $past(seq_ctrl_q) && lut_in_q == $past(lut_in_q)))
    else $error("status write changed a register");
  a_bus_status_bits: assert property (
    (s_bus_req ##0 (!wb_we_i && hit_status))
    |=> (wb_dat_o[ST_FF] == $past(ff_q_o) && wb_dat_o[ST_VOTE] == $past(voted)))
    else $error("status read shows wrong flip-flop or vote");

  a_lut_one_pick: assert property (lut1_y == (in_a ? lut_init_q[LUT1_LSB + 1]
                                                   : lut_init_q[LUT1_LSB]))
    else $error("one-input lut wrong");
  a_lut_two_pick: assert property (
    (in_b && !in_a) |-> lut2_y == lut_init_q[LUT2_LSB + 2])
    else $error("two-input lut index order wrong");
  a_lut_three_pick: assert property (
    (in_c && !in_b && in_a) |-> lut3_y == lut_init_q[LUT3_LSB + 5])
    else $error("three-input lut index order wrong");
  a_lut_four_pick: assert property (
    (in_d && !in_c && !in_b && in_a) |-> lut4_y == lut_init_q[LUT4_LSB + 9])
    else $error("four-input lut index order wrong");
  a_lut_two_high: assert property (
    (in_b && in_a) |-> lut2_y == lut_init_q[LUT2_LSB + 3])
    else $error("two-input lut top entry wrong");
  a_lut_two_low: assert property (
    (!in_b && in_a) |-> lut2_y == lut_init_q[LUT2_LSB + 1])
    else $error("two-input lut a entry wrong");
  a_lut_three_six: assert property (
    (in_c && in_b && !in_a) |-> lut3_y == lut_init_q[LUT3_LSB + 6])
    else $error("three-input lut entry six wrong");
  a_lut_four_six: assert property (
    (!in_d && in_c && in_b && !in_a) |-> lut4_y == lut_init_q[LUT4_LSB + 6])
    else $error("four-input lut entry six wrong");

  a_seq_hold_off: assert property (
    (se_al_n && !se_en) |=> (!se_al_n || seq_q == $past(seq_q)))
    else $error("element changed while disabled");
  a_seq_async_force: assert property (!se_al_n |-> (seq_q_o == ~se_alv_n)
    ##1 (seq_q == ~$past(se_alv_n)))
    else $error("async load did not force output");
  a_seq_sync_load: assert property ((s_seq_clocked ##0 !se_sl_n)
    |=> seq_q == $past(se_slv))
    else $error("sync load value not taken");
  a_seq_data_take: assert property ((s_seq_clocked ##0 se_sl_n)
    |=> seq_q == $past(se_data))
    else $error("data not captured on enabled edge");
  a_seq_out_reg: assert property (se_al_n |-> seq_q_o == seq_q)
    else $error("element output not from its register");
  a_seq_async_first: assert property ((!se_al_n && se_en)
    |=> seq_q == ~$past(se_alv_n))
    else $error("clocked load beat async load");
  a_seq_sync_gated: assert property (
    (se_al_n && !se_latch && !se_en && !se_sl_n) |=> seq_q == $past(seq_q))
    else $error("sync load took effect without enable");

  a_row_copy: assert property (
    row_out_left_o == row_in && row_out_right_o == row_in)
    else $error("row buffer sides differ from input");
  a_vote_two_agree: assert property (
    (vote_in[2] == vote_in[0]) |-> voted_local_reset_o == vote_in[0])
    else $error("vote ignored two agreeing inputs");
  a_vote_low_pair: assert property (
    (vote_in[1:0] == 2'b00) |-> !voted_local_reset_o)
    else $error("vote high with two low inputs");
  a_vote_high_pair: assert property (
    (vote_in[1:0] == 2'b11) |-> voted_local_reset_o)
    else $error("vote low with two high inputs");
  a_vote_split_third: assert property (
    (vote_in[0] != vote_in[1]) |-> voted_local_reset_o == vote_in[2])
    else $error("split vote not decided by third input");

endmodule

/* testbench/fle_user_model.sv */
// user fabric model: classic wishbone master driving the block's registers
// assumes the block acks after taking a request; bench calls xfer
module fle_user_model (
  input  wire logic                       clk_i,
  input  wire logic                       wb_ack_i,
  input  wire logic [fle_pkg::FLE_DW-1:0] wb_dat_i,
  output logic                            wb_cyc_o,
  output logic                            wb_stb_o,
  output logic                            wb_we_o,
  output logic      [fle_pkg::FLE_AW-1:0] wb_adr_o,
  output logic      [3:0]                 wb_sel_o,
  output logic      [fle_pkg::FLE_DW-1:0] wb_dat_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import fle_pkg::*;
  logic tmo;
  initial begin
    {wb_cyc_o, wb_stb_o, wb_we_o, tmo} = '0;
    wb_adr_o = '0;
    wb_sel_o = '0;
    wb_dat_o = '0;
  end
  // static load values and latch select come only from the bench's writes
  task automatic xfer(input logic we, input logic [FLE_AW-1:0] a, input logic [FLE_DW-1:0] d,
                      input logic [3:0] s, output logic [FLE_DW-1:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o  <= we;
    wb_adr_o <= a;
    wb_sel_o <= s;
    wb_dat_o <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_i !== 1'b1 && n < 40);
    tmo = (wb_ack_i !== 1'b1);
    q = wb_dat_i;
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    // released lines show junk, not the last value
    wb_adr_o <= ~a;
    wb_dat_o <= ~d;
  endtask
endmodule

/* testbench/fle_fabric_bench.sv */
// self-checking bench for the fabric logic element block
// assumes dut has the default variant, dut2 the falling-edge inverted one
`define FLE_CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin error_cnt++; \
  $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module fle_fabric_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import fle_pkg::*;
  logic clk_i, rst_i, cyc, stb, we, ack, seq_q, ff_q, ff2_q, row_l, row_r, vote;
  logic [FLE_AW-1:0] adr;
  logic [3:0]        sel;
  logic [FLE_DW-1:0] wdat, rdat;
  int                error_cnt = 0;
  int                n_compared = 0;
  localparam logic [31:0] INIT = 32'h22e3_c5a9;
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  fle_fabric dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .seq_q_o(seq_q), .ff_q_o(ff_q), .row_out_left_o(row_l), .row_out_right_o(row_r),
    .voted_local_reset_o(vote));
  // second variant: falling edge, enable low, preset and clear high, inverted output
  fle_fabric #(.FF_CLK_POL(1'b0), .FF_EN_OPT(FLE_OPT_ACT_LOW), .FF_PRE_OPT(FLE_OPT_ACT_HIGH),
    .FF_CLR_OPT(FLE_OPT_ACT_HIGH), .FF_INV_OUT(1'b1)) dut2 (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(), .wb_ack_o(), .seq_q_o(), .ff_q_o(ff2_q),
    .row_out_left_o(), .row_out_right_o(), .voted_local_reset_o());
  fle_user_model usr (.clk_i(clk_i), .wb_ack_i(ack), .wb_dat_i(rdat), .wb_cyc_o(cyc),
    .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wdat));
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic rd(input logic [FLE_AW-1:0] a, output logic [31:0] q);
    usr.xfer(1'b0, a, 32'h0, 4'hf, q);
    if (usr.tmo) begin
      error_cnt++;
      tally_and_finish;
    end
  endtask
  task automatic wr(input logic [FLE_AW-1:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] q;
    usr.xfer(1'b1, a, d, s, q);
    if (usr.tmo) begin
      error_cnt++;
      tally_and_finish;
    end
  endtask
  task automatic chk_rd(input logic [FLE_AW-1:0] a, input logic [31:0] e);
    logic [31:0] q;
    rd(a, q);
    `FLE_CHK("read data", e, q)
  endtask
  task automatic t_reset;
    chk_rd(ADDR_LUT_INIT, LUT_INIT_RST);
    chk_rd(ADDR_LUT_IN, {28'h0, LUT_IN_RST});
    chk_rd(ADDR_SEQ_CTRL, {17'h0, SEQ_CTRL_RST});
    chk_rd(ADDR_STATUS, 32'h0);
  endtask
  task automatic t_luts;
    logic [31:0] st;
    wr(ADDR_LUT_INIT, INIT, 4'hf);
    for (int i = 0; i < 16; i++) begin
      wr(ADDR_LUT_IN, i, 4'hf);
      rd(ADDR_STATUS, st);
      `FLE_CHK("one-input lut", INIT[28 + i % 2], st[0])
      `FLE_CHK("two-input lut", INIT[24 + i % 4], st[1])
      `FLE_CHK("three-input lut", INIT[16 + i % 8], st[2])
      `FLE_CHK("four-input lut", INIT[i], st[3])
    end
  endtask
  // ctrl, expected element, variant and second variant outputs; latch select stays low
  localparam logic [17:0] SEQ_TAB [16] = '{{15'h415, 3'b001}, {15'h597, 3'b111},
    {15'h416, 3'b011}, {15'h526, 3'b101}, {15'h404, 3'b101}, {15'h406, 3'b001},
    {15'h592, 3'b111}, {15'h19a, 3'b001}, {15'h417, 3'b101}, {15'h094, 3'b100},
    {15'h194, 3'b100}, {15'h114, 3'b100}, {15'h014, 3'b101}, {15'h214, 3'b100},
    {15'h614, 3'b101}, {15'h094, 3'b100}};
  task automatic t_seq;
    for (int i = 0; i < 16; i++) begin
      wr(ADDR_SEQ_CTRL, {17'h0, SEQ_TAB[i][17:3]}, 4'hf);
      @(posedge clk_i);
      #1;
      `FLE_CHK("element output", SEQ_TAB[i][2], seq_q)
      `FLE_CHK("variant output", SEQ_TAB[i][1], ff_q)
      `FLE_CHK("second variant output", SEQ_TAB[i][0], ff2_q)
    end
  endtask
  task automatic t_row_vote;
    logic [2:0] v;
    for (int i = 0; i < 8; i++) begin
      v = 3'(i);
      wr(ADDR_SEQ_CTRL, {17'h0, v, v[0], 11'h414}, 4'hf);
      #1;
      `FLE_CHK("row left", v[0], row_l)
      `FLE_CHK("row right", v[0], row_r)
      `FLE_CHK("vote", (v[0] & v[1]) | (v[1] & v[2]) | (v[0] & v[2]), vote)
    end
  endtask
  task automatic t_bus;
    chk_rd(8'h10, 32'h0);
    wr(8'h10, 32'hffff_ffff, 4'hf);
    wr(ADDR_SEQ_CTRL, 32'hffff_0414, 4'hf);
    wr(ADDR_STATUS, 32'hffff_ffff, 4'hf);
    chk_rd(ADDR_SEQ_CTRL, 32'h0000_0414);
    wr(ADDR_LUT_INIT, 32'hffff_ffff, 4'h1);
    chk_rd(ADDR_LUT_INIT, {INIT[31:8], 8'hff});
  endtask
  initial begin
    rst_i = 1'b1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    `FLE_CHK("element after reset", 1'b0, seq_q)
    `FLE_CHK("variant after reset", 1'b0, ff_q)
    `FLE_CHK("second variant after reset", 1'b1, ff2_q)
    t_reset;
    t_luts;
    t_seq;
    t_row_vote;
    t_bus;
    tally_and_finish;
  end
endmodule
